/* core/fcrir_flash_ctrl.sv */
// flash control front end: reset-time load, command buffer, interrupts, regs
//
// Operation
// RULE1: the bus stays stalled after reset until both config bytes load.
// RULE2: a reset aborts a running program or erase command at once.
// RULE3: buffers-empty with its enable set requests an interrupt.
// RULE4: commands-complete with its enable set requests an interrupt.
// RULE5: each flag is gated by its own enable; a disabled flag gives none.
// RULE6: sixteen byte-wide registers are decoded at indices 0x0 to 0xF.
// RULE7: the factory-test registers read as zero and ignore writes.
// RULE8: the system assigns vectors and priority of both interrupt sources.
// RULE9: irq is one level, the OR of both enabled flags, held until cleared.
//
// Design decision made here: the Avalon-MM register port.
module fcrir_flash_ctrl
	import fcrir_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// nonvolatile byte fetch
	output logic             nvm_rd_req,
	output logic [15:0]      nvm_rd_addr,
	input  wire logic [7:0]  nvm_rd_data,
	input  wire logic        nvm_rd_valid,
	// flash array command port
	output logic             array_cmd_valid,
	output fcrir_cmd_s       array_cmd,
	input  wire logic        array_cmd_done,
	input  wire logic        array_cmd_fail,
	output logic             array_abort,
	// processor side
	output logic             cpu_hold,
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////
	// state

	fcrir_load_e load_state;
	fcrir_load_e next_load_state;

	logic [7:0] clock_divider_ctrl;
	logic [7:0] security_config;
	logic [7:0] module_config;
	logic [7:0] protection_config;
	logic [7:0] command_code;
	logic [7:0] test_address_high;
	logic [7:0] test_address_low;
	logic [7:0] test_data_high;
	logic [7:0] test_data_low;

	logic buffers_empty_flag;
	logic commands_complete_flag;
	logic access_error;
	logic command_fail;
	logic cmd_staged;
	logic buf_full;
	logic engine_busy;
	logic rd_ack;
	fcrir_cmd_s buf_cmd;

	function automatic logic reg_hit(input logic [3:0] addr,
			input logic [3:0] idx);
		reg_hit = (addr == idx);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// reset-time load sequence

	wire loading = (load_state != ST_RUN);

	// an illegal code restarts the load rather than run unloaded
	always_comb begin
		next_load_state = load_state;
		unique case (load_state)
			ST_LOAD_SEC: begin
				if (nvm_rd_valid) begin
					next_load_state = ST_LOAD_PROT;
				end
			end
			ST_LOAD_PROT: begin
				if (nvm_rd_valid) begin
					next_load_state = ST_RUN;
				end
			end
			ST_RUN: begin
				next_load_state = ST_RUN;
			end
			default: begin
				next_load_state = ST_LOAD_SEC;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			load_state <= ST_LOAD_SEC;
		end else begin
			load_state <= next_load_state; // RULE1
		end
	end

	// security byte first, protection second
	assign nvm_rd_req  = loading;
	assign nvm_rd_addr = (load_state == ST_LOAD_PROT) ? NVM_PROT_ADDR
		: NVM_SEC_ADDR;
	// the processor stays held until the second byte has landed
	assign cpu_hold    = loading; // RULE1

	////////////////////////////////////////////////////////////////////////
	// bus decode

	// reads take one wait state so read data come from a flip-flop
	assign avs_waitrequest = loading | (avs_read & ~rd_ack); // RULE1

	// every register sits in byte lane 0; a write without it is dropped
	wire wr_go  = avs_write & ~loading & avs_byteenable[0];
	wire rd_go  = avs_read & ~loading & ~rd_ack;
	wire [7:0] wbyte = avs_writedata[7:0];

	wire wr_div  = wr_go & reg_hit(avs_address, IDX_CLOCK_DIVIDER_CTRL);
	wire wr_cfg  = wr_go & reg_hit(avs_address, IDX_MODULE_CONFIG);
	wire wr_prot = wr_go & reg_hit(avs_address, IDX_PROTECTION_CONFIG);
	wire wr_stat = wr_go & reg_hit(avs_address, IDX_MODULE_STATUS);
	wire wr_cmd  = wr_go & reg_hit(avs_address, IDX_COMMAND_CODE);
	wire wr_tah  = wr_go & reg_hit(avs_address, IDX_TEST_ADDRESS_HIGH);
	wire wr_tal  = wr_go & reg_hit(avs_address, IDX_TEST_ADDRESS_LOW);
	wire wr_tdh  = wr_go & reg_hit(avs_address, IDX_TEST_DATA_HIGH);
	wire wr_tdl  = wr_go & reg_hit(avs_address, IDX_TEST_DATA_LOW);

	// writing one to the empty flag launches the staged command
	wire launch_req = wr_stat & wbyte[BUF_EMPTY_BIT];
	wire launch_ok  = launch_req & buffers_empty_flag & cmd_staged;
	wire launch_bad = launch_req & ~(buffers_empty_flag & cmd_staged);

	// buffer hands over to the engine when the engine is free
	wire issue = buf_full & ~engine_busy;

	////////////////////////////////////////////////////////////////////////
	// read path

	wire [7:0] status_view;
	assign status_view = {buffers_empty_flag, commands_complete_flag, 1'b0,
		access_error, 2'b00, command_fail, 1'b0};

	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = ZERO_BYTE;
		unique case (avs_address)
			IDX_CLOCK_DIVIDER_CTRL: rd_mux = clock_divider_ctrl;
			IDX_SECURITY_CONFIG:    rd_mux = security_config;
			IDX_MODULE_CONFIG:      rd_mux = module_config;
			IDX_PROTECTION_CONFIG:  rd_mux = protection_config;
			IDX_MODULE_STATUS:      rd_mux = status_view;
			IDX_COMMAND_CODE:       rd_mux = command_code;
			IDX_TEST_ADDRESS_HIGH:  rd_mux = test_address_high;
			IDX_TEST_ADDRESS_LOW:   rd_mux = test_address_low;
			IDX_TEST_DATA_HIGH:     rd_mux = test_data_high;
			IDX_TEST_DATA_LOW:      rd_mux = test_data_low;
			// reserved and factory-test slots: zero, never writable
			IDX_UNNAMED_RESERVED,
			IDX_RESERVED_SEVEN,
			IDX_FACTORY_TEST_C,
			IDX_FACTORY_TEST_D,
			IDX_FACTORY_TEST_E,
			IDX_FACTORY_TEST_F:     rd_mux = ZERO_BYTE; // RULE6 RULE7
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rd_ack       <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			// rd_ack drops after the taken edge, so a held read restarts
			rd_ack <= rd_go;
			if (rd_go) begin
				avs_readdata <= {24'h00_0000, rd_mux};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// loaded and software registers

	// security is set only by the load; the bus cannot write it
	always_ff @(posedge clk) begin
		if (srst) begin
			security_config   <= ZERO_BYTE;
			protection_config <= ZERO_BYTE;
		end else if (nvm_rd_valid && load_state == ST_LOAD_SEC) begin
			security_config <= nvm_rd_data; // RULE1
		end else if (nvm_rd_valid && load_state == ST_LOAD_PROT) begin
			protection_config <= nvm_rd_data; // RULE1
		end else if (wr_prot && protection_config[PROT_OPEN_BIT]) begin
			// protection bits 6:0 may be rewritten either way, but only while it is still open
			protection_config <= (protection_config & ~PROT_WR_MASK)
				| (wbyte & PROT_WR_MASK);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			clock_divider_ctrl <= ZERO_BYTE;
			module_config      <= ZERO_BYTE;
			command_code       <= ZERO_BYTE;
			test_address_high  <= ZERO_BYTE;
			test_address_low   <= ZERO_BYTE;
			test_data_high     <= ZERO_BYTE;
			test_data_low      <= ZERO_BYTE;
		end else begin
			// top bit flags a divider write since reset
			if (wr_div) begin
				clock_divider_ctrl <= (wbyte & DIV_WR_MASK)
					| (ZERO_BYTE | (8'h01 << DIV_LOADED_BIT));
			end
			if (wr_cfg) begin
				module_config <= wbyte & CFG_WR_MASK;
			end
			if (wr_cmd) begin
				command_code <= wbyte & CMD_WR_MASK;
			end
			// address and data pair into the command at launch
			if (wr_tah) begin
				test_address_high <= wbyte;
			end
			if (wr_tal) begin
				test_address_low <= wbyte;
			end
			if (wr_tdh) begin
				test_data_high <= wbyte;
			end
			if (wr_tdl) begin
				test_data_low <= wbyte;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// command buffer and engine

	// one command may wait here while the engine runs the one before;
	// the staged flag stops a second launch replaying an old code
	always_ff @(posedge clk) begin
		if (srst) begin
			cmd_staged <= 1'b0;
			buf_full   <= 1'b0;
			buf_cmd    <= '0;
		end else begin
			if (wr_cmd) begin
				cmd_staged <= 1'b1;
			end else if (launch_ok) begin
				cmd_staged <= 1'b0;
			end
			if (launch_ok) begin
				buf_full <= 1'b1;
				buf_cmd  <= '{code: command_code[6:0],
					addr: {test_address_high, test_address_low},
					data: {test_data_high, test_data_low}};
			end else if (issue) begin
				buf_full <= 1'b0;
			end
		end
	end

	// reset clears busy at once, so the array is told to drop its work
	// whatever the aborted command was writing is left undefined
	assign array_abort = srst & engine_busy; // RULE2

	always_ff @(posedge clk) begin
		if (srst) begin
			engine_busy     <= 1'b0; // RULE2
			array_cmd_valid <= 1'b0;
			array_cmd       <= '0;
		end else begin
			array_cmd_valid <= issue;
			if (issue) begin
				engine_busy <= 1'b1;
				array_cmd   <= buf_cmd;
			end else if (array_cmd_done) begin
				engine_busy <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status flags; a hardware set wins over a same-cycle clear

	wire empty_set = issue;
	// completion is reported only once nothing is left waiting
	wire done_set  = engine_busy & ~issue & array_cmd_done & ~buf_full;

	always_ff @(posedge clk) begin
		if (srst) begin
			buffers_empty_flag     <= STATUS_RESET[BUF_EMPTY_BIT];
			commands_complete_flag <= STATUS_RESET[CMD_DONE_BIT];
			access_error           <= 1'b0;
			command_fail           <= 1'b0;
		end else begin
			if (empty_set) begin
				buffers_empty_flag <= 1'b1;
			end else if (launch_ok) begin
				buffers_empty_flag <= 1'b0;
			end
			if (done_set) begin
				commands_complete_flag <= 1'b1;
			end else if (launch_ok) begin
				commands_complete_flag <= 1'b0;
			end
			// a launch with no staged code or a busy buffer is refused
			if (launch_bad) begin
				access_error <= 1'b1;
			end else if (wr_stat && wbyte[ACC_ERR_BIT]) begin
				access_error <= 1'b0;
			end
			if (engine_busy && array_cmd_done && array_cmd_fail) begin
				command_fail <= 1'b1;
			end else if (wr_stat && wbyte[CMD_FAIL_BIT]) begin
				command_fail <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt

	// each enable sits in the config register at its flag's position
	wire empty_req = buffers_empty_flag
		& module_config[BUF_EMPTY_BIT]; // RULE3 RULE5
	wire done_req  = commands_complete_flag
		& module_config[CMD_DONE_BIT]; // RULE4 RULE5

	// one level line; vector and priority are left to the system
	assign irq = empty_req | done_req; // RULE9 RULE8

endmodule // fcrir_flash_ctrl

/* core/fcrir_pkg.sv */
// package: register map, field positions and types of the flash control block
package fcrir_pkg;

	// register indices; byte address on the bus is four times the index
	localparam logic [3:0] IDX_CLOCK_DIVIDER_CTRL = 4'h0;
	localparam logic [3:0] IDX_SECURITY_CONFIG    = 4'h1;
	localparam logic [3:0] IDX_UNNAMED_RESERVED   = 4'h2;
	localparam logic [3:0] IDX_MODULE_CONFIG      = 4'h3;
	localparam logic [3:0] IDX_PROTECTION_CONFIG  = 4'h4;
	localparam logic [3:0] IDX_MODULE_STATUS      = 4'h5;
	localparam logic [3:0] IDX_COMMAND_CODE       = 4'h6;
	localparam logic [3:0] IDX_RESERVED_SEVEN     = 4'h7;
	localparam logic [3:0] IDX_TEST_ADDRESS_HIGH  = 4'h8;
	localparam logic [3:0] IDX_TEST_ADDRESS_LOW   = 4'h9;
	localparam logic [3:0] IDX_TEST_DATA_HIGH     = 4'hA;
	localparam logic [3:0] IDX_TEST_DATA_LOW      = 4'hB;
	localparam logic [3:0] IDX_FACTORY_TEST_C     = 4'hC;
	localparam logic [3:0] IDX_FACTORY_TEST_D     = 4'hD;
	localparam logic [3:0] IDX_FACTORY_TEST_E     = 4'hE;
	localparam logic [3:0] IDX_FACTORY_TEST_F     = 4'hF;

	// field positions
	localparam int DIV_LOADED_BIT   = 7;
	localparam int PROT_OPEN_BIT    = 7;
	localparam int BUF_EMPTY_BIT    = 7;
	localparam int CMD_DONE_BIT     = 6;
	localparam int ACC_ERR_BIT      = 4;
	localparam int CMD_FAIL_BIT     = 1;

	// writable masks and reset values
	localparam logic [7:0] DIV_WR_MASK    = 8'h7F;
	localparam logic [7:0] CFG_WR_MASK    = 8'hC0;
	localparam logic [7:0] PROT_WR_MASK   = 8'h7F;
	localparam logic [7:0] CMD_WR_MASK    = 8'h7F;
	localparam logic [7:0] ZERO_BYTE      = 8'h00;
	localparam logic [7:0] STATUS_RESET   = 8'hC0;

	// nonvolatile locations fetched at reset (plain defaults)
	localparam logic [15:0] NVM_SEC_ADDR  = 16'hFF0F;
	localparam logic [15:0] NVM_PROT_ADDR = 16'hFF0D;

	// reset-time load sequence
	typedef enum logic [2:0] {
		ST_LOAD_SEC  = 3'b001,
		ST_LOAD_PROT = 3'b010,
		ST_RUN       = 3'b100
	} fcrir_load_e;

	// one command handed to the flash array
	typedef struct packed {
		logic [6:0]  code;
		logic [15:0] addr;
		logic [15:0] data;
	} fcrir_cmd_s;

endpackage

/* verif/fcrir_checker.sv */
// port assertions for the flash control front end
module fcrir_checker
	import fcrir_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        srst,
	// register bus
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// far side and processor
	input wire logic        nvm_rd_req,
	input wire logic        nvm_rd_valid,
	input wire logic        array_cmd_valid,
	input wire logic        array_cmd_done,
	input wire logic        array_abort,
	input wire logic        cpu_hold,
	input wire logic        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire rd_done = avs_read && !avs_waitrequest;
	wire rsvd = avs_address >= IDX_FACTORY_TEST_C
		|| avs_address == IDX_RESERVED_SEVEN;
	hold_stall_a: assert property (cpu_hold |-> avs_waitrequest)
		else $error("bus not stalled during load");
	hold_free_a: assert property ($fell(cpu_hold)
		|-> $past(nvm_rd_valid) && !nvm_rd_req)
		else $error("hold released without fetch");
	abort_cause_a: assert property (array_abort |-> srst)
		else $error("abort without reset");
	abort_on_rst_a: assert property (disable iff (1'b0)
		srst && !$past(srst) && $past(array_cmd_valid) |-> array_abort)
		else $error("running command not aborted");
	rd_wait_a: assert property ($rose(avs_read) && !cpu_hold
		|-> avs_waitrequest) else $error("read answered early");
	rd_upper_a: assert property (rd_done
		|-> avs_readdata[31:8] == 24'h0) else $error("upper bits set");
	rsvd_zero_a: assert property (rd_done && rsvd
		|-> avs_readdata == 32'h0) else $error("reserved not zero");
	irq_rise_a: assert property ($rose(irq) |-> $past(avs_write)
		|| array_cmd_valid || $past(array_cmd_done))
		else $error("irq rose without cause");
	irq_fall_a: assert property ($fell(irq)
		|-> $past(avs_write) || $past(srst))
		else $error("irq fell without software");
	cover property ($fell(cpu_hold));
	cover property ($rose(irq));
	cover property (array_cmd_valid ##[1:100] array_cmd_done);
endmodule // fcrir_checker

bind fcrir_flash_ctrl fcrir_checker chk_u (.clk, .srst, .avs_address,
	.avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .nvm_rd_req,
	.nvm_rd_valid, .array_cmd_valid, .array_cmd_done, .array_abort,
	.cpu_hold, .irq);

/* verif/fcrir_far_model.sv */
// far side: nonvolatile byte source and flash array engine
module fcrir_far_model
	import fcrir_pkg::*;
#(
	parameter logic [7:0] SEC_VAL  = 8'hA5,
	parameter logic [7:0] PROT_VAL = 8'h80
)(
	// clock and reset
	input wire logic        clk,
	input wire logic        srst,
	// byte fetch
	input wire logic        nvm_rd_req,
	input wire logic [15:0] nvm_rd_addr,
	output logic [7:0]      nvm_rd_data,
	output logic            nvm_rd_valid,
	// array engine
	input wire logic        array_cmd_valid,
	input wire logic        array_abort,
	input wire logic [7:0]  dly,
	output logic            array_cmd_done,
	output logic            array_cmd_fail
);
	logic [1:0] gap;
	logic [7:0] cnt;
	logic       busy;
	// data toggles outside the valid pulse so stale bytes never match
	always_ff @(posedge clk) begin
		nvm_rd_valid <= 1'b0;
		if (srst) begin
			gap <= 2'h0;
			nvm_rd_data <= 8'h5A;
		end else if (!nvm_rd_req || nvm_rd_valid || gap != 2'h2) begin
			gap <= nvm_rd_req && !nvm_rd_valid ? gap + 2'h1 : 2'h0;
			nvm_rd_data <= ~nvm_rd_data;
		end else begin
			nvm_rd_valid <= 1'b1;
			nvm_rd_data <= nvm_rd_addr == NVM_SEC_ADDR ? SEC_VAL : PROT_VAL;
		end
	end
	always_ff @(posedge clk) begin
		array_cmd_done <= 1'b0;
		array_cmd_fail <= 1'b0;
		if (srst || array_abort) begin
			busy <= 1'b0;
		end else if (array_cmd_valid) begin
			busy <= 1'b1;
			cnt <= dly;
		end else if (busy && cnt == 8'h0) begin
			busy <= 1'b0;
			array_cmd_done <= 1'b1;
		end else begin
			cnt <= cnt - 8'h1;
		end
	end
endmodule // fcrir_far_model

/* verif/tb.sv */
// self-checking bench for the flash control front end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, srst, avs_read, avs_write, avs_waitrequest;
	logic [3:0]  avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata;
	logic        nvm_rd_req, nvm_rd_valid, array_cmd_valid, array_abort;
	logic        array_cmd_done, array_cmd_fail, cpu_hold, irq;
	logic [15:0] nvm_rd_addr;
	logic [7:0]  nvm_rd_data, dly, q;
	fcrir_pkg::fcrir_cmd_s array_cmd;
	int          mismatches, n_tests, i;
	// index, write data, byte enables, expected read
	logic [23:0] rows [14] = '{24'h0_05_1_85, 24'h1_FF_1_A5,
		24'h2_FF_1_00, 24'h4_55_1_D5, 24'h7_FF_1_00, 24'h8_12_1_12,
		24'h8_FF_0_12, 24'h9_34_1_34, 24'hA_56_1_56, 24'hB_78_1_78,
		24'hC_FF_1_00, 24'hD_FF_1_00, 24'hE_FF_1_00, 24'hF_FF_1_00};
	fcrir_flash_ctrl dut_u (.clk, .srst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .nvm_rd_req, .nvm_rd_addr, .nvm_rd_data,
		.nvm_rd_valid, .array_cmd_valid, .array_cmd, .array_cmd_done,
		.array_cmd_fail, .array_abort, .cpu_hold, .irq);
	fcrir_far_model far_u (.clk, .srst, .nvm_rd_req, .nvm_rd_addr,
		.nvm_rd_data, .nvm_rd_valid, .array_cmd_valid, .array_abort, .dly,
		.array_cmd_done, .array_cmd_fail);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// sel 0 waits for the command pulse, sel 1 for the done pulse
	task automatic wait_hi(input int sel);
		logic s;
		s = 1'b0;
		repeat (200) begin
			@(negedge clk);
			s = (sel == 0) ? array_cmd_valid : array_cmd_done;
			if (s === 1'b1)
				break;
		end
		chk({7'h0, s}, 8'h01);
		if (s !== 1'b1)
			end_of_test;
	endtask
	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [7:0] d, input logic [3:0] be);
		int   k;
		logic ok;
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		k = 0;
		ok = 1'b0;
		while (!ok && k < 200) begin
			@(posedge clk);
			ok = (avs_waitrequest === 1'b0);
			k++;
		end
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (!ok) begin
			chk(8'h00, 8'h01);
			end_of_test;
		end
	endtask
	task irq_is(input logic e);
		@(negedge clk);
		chk({7'h0, irq}, {7'h0, e});
	endtask
	initial begin
		srst = 1'b1;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'h0;
		dly = 8'h03;
		mismatches = 0;
		n_tests = 0;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		chk({7'h0, cpu_hold & avs_waitrequest}, 8'h01);
		bus(1'b0, 4'h5, 8'h00, 4'hF);
		chk(q, 8'hC0);
		$display("test reset_load ended");
		for (i = 0; i < 14; i++) begin
			bus(1'b1, rows[i][23:20], rows[i][19:12], rows[i][11:8]);
			bus(1'b0, rows[i][23:20], 8'h00, 4'hF);
			chk(q, rows[i][7:0]);
		end
		$display("test register_map ended");
		// one level output; vectors and priority stay with the system
		bus(1'b1, 4'h3, 8'h80, 4'h1);
		irq_is(1'b1);
		bus(1'b1, 4'h3, 8'h40, 4'h1);
		irq_is(1'b1);
		bus(1'b1, 4'h3, 8'h00, 4'h1);
		irq_is(1'b0);
		bus(1'b1, 4'h3, 8'h40, 4'h1);
		bus(1'b1, 4'h6, 8'h20, 4'h1);
		bus(1'b1, 4'h5, 8'h80, 4'h1);
		irq_is(1'b0);
		wait_hi(0);
		chk({1'b0, array_cmd.code}, 8'h20);
		chk(array_cmd.addr[15:8], 8'h12);
		chk(array_cmd.addr[7:0], 8'h34);
		chk(array_cmd.data[15:8], 8'h56);
		chk(array_cmd.data[7:0], 8'h78);
		irq_is(1'b0);
		wait_hi(1);
		irq_is(1'b1);
		$display("test interrupts ended");
		dly = 8'h60;
		bus(1'b1, 4'h6, 8'h20, 4'h1);
		bus(1'b1, 4'h5, 8'h80, 4'h1);
		wait_hi(0);
		@(posedge clk);
		srst <= 1'b1;
		@(negedge clk);
		chk({7'h0, array_abort}, 8'h01);
		@(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		chk({7'h0, cpu_hold}, 8'h01);
		bus(1'b0, 4'h5, 8'h00, 4'hF);
		chk(q, 8'hC0);
		$display("test reset_abort ended");
		// launch with no staged code is refused and flagged
		bus(1'b1, 4'h5, 8'h80, 4'h1);
		bus(1'b0, 4'h5, 8'h00, 4'hF);
		chk(q, 8'hD0);
		bus(1'b1, 4'h5, 8'h10, 4'h1);
		bus(1'b0, 4'h5, 8'h00, 4'hF);
		chk(q, 8'hC0);
		$display("test access_error ended");
		end_of_test;
	end
endmodule // tb
